//--- common/adt_pkg.sv
// Package of constants and types for the gain-control dwell timer
package adt_pkg;

  // Dwell-select field
  localparam int          SEL_W       = 3;
  localparam logic [2:0]  SEL_OFF     = 3'h0;
  // Exponent for code 1, and step per code
  localparam int          K_BASE      = 11;
  localparam int          K_STEP      = 2;
  localparam int          K_MAX       = 23;
  // Counter wide enough for 2^K_MAX cycles
  localparam int          CNT_W       = K_MAX + 1;
  // Length of the peak-track pulse on a gain change, in clock cycles
  localparam int          TRACK_CYC   = 1;

  // Gain states
  typedef enum logic [1:0] {
    ADT_HIGH  = 2'b00,  // Full gain, attenuator off
    ADT_LOW   = 2'b01,  // Attenuated, level not below lower threshold
    ADT_DWELL = 2'b10   // Attenuated, timing the dwell interval
  } adt_state_t;

endpackage : adt_pkg

//--- hdl/adt_dwell_timer.sv
// Dwell timer and gain-state control for a receiver gain controller
// Notes on behaviour
// [RULE1] Select code zero disables control; amplifier stays in high gain.
// [RULE2] Codes one to seven give K of 11 to 23, step two.
// [RULE3] Dwell lasts exactly 2^K reference clock periods.
// [RULE4] Below lower threshold in low gain, hold low gain for the full dwell.
// [RULE5] At dwell end with level still low, return to high gain.
// [RULE6] Host picks at least two bit periods for Manchester traffic.
// [RULE7] Host picks more than the longest identical run for NRZ traffic.
// [RULE8] Host computes 3.3*log10(time*frequency) and takes next higher odd K.
// [RULE9] With control on, upper threshold crossing enters low gain.
// [RULE10] Level counts as low only while under the lower threshold.
// [RULE11] Every gain change pulses the peak-detector track request; reset drops low gain with no pulse.
// [RULE12] Rising above upper threshold mid-dwell keeps low gain, restarts count later.
`timescale 1ns/1ps
module adt_dwell_timer (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Dwell-select pins from the host
  input  wire logic        dwell_select_bit0,
  input  wire logic        dwell_select_bit1,
  input  wire logic        dwell_select_bit2,
  // Level comparator outputs
  input  wire logic        level_above_upper,
  input  wire logic        level_below_lower,
  // Gain control outputs
  output      logic        low_gain,
  output      logic        peak_track,
  output      logic        dwell_active
);

  // Whole state of the module
  typedef struct packed {
    adt_pkg::adt_state_t          st;
    logic [adt_pkg::CNT_W-1:0]    cnt;
    logic                         low_gain;
    logic                         peak_track;
  } adt_regs_t;

  adt_regs_t                   r;
  adt_regs_t                   next_r;
  logic                        agc_on;
  logic [adt_pkg::CNT_W-1:0]   limit;

  // Code decode; pins are synchronous to the clock
  adt_limit u_limit (
    .code   ({dwell_select_bit2, dwell_select_bit1, dwell_select_bit0}),
    .agc_on (agc_on),
    .limit  (limit)
  );

  // Next-state logic
  always_comb begin
    next_r            = r;
    next_r.peak_track = 1'b0;
    unique case (r.st)
      adt_pkg::ADT_HIGH: begin
        next_r.cnt = '0;
        if (agc_on && level_above_upper) begin
          next_r.st = adt_pkg::ADT_LOW;                        // [RULE9]
        end
      end
      adt_pkg::ADT_LOW: begin
        next_r.cnt = '0;
        if (level_below_lower && !level_above_upper) begin
          next_r.st  = adt_pkg::ADT_DWELL;                     // [RULE10]
          next_r.cnt = adt_pkg::CNT_W'(1);                     // [RULE4]
        end
      end
      adt_pkg::ADT_DWELL: begin
        if (level_above_upper) begin
          // Strong signal again: stay attenuated, count anew next time
          next_r.st  = adt_pkg::ADT_LOW;                       // [RULE12]
          next_r.cnt = '0;
        end else if (!level_below_lower) begin
          // Between thresholds: hysteresis band, wait for a fresh low crossing
          next_r.st  = adt_pkg::ADT_LOW;                       // [RULE10]
          next_r.cnt = '0;
        end else if (r.cnt >= limit) begin
          next_r.st  = adt_pkg::ADT_HIGH;                      // [RULE5]
          next_r.cnt = '0;
        end else begin
          next_r.cnt = r.cnt + adt_pkg::CNT_W'(1);             // [RULE3]
        end
      end
      default: begin
        next_r.st  = adt_pkg::ADT_HIGH;
        next_r.cnt = '0;
      end
    endcase
    // Disabling forces high gain at once, whatever the state
    if (!agc_on) begin
      next_r.st  = adt_pkg::ADT_HIGH;                          // [RULE1]
      next_r.cnt = '0;
    end
    next_r.low_gain = (next_r.st != adt_pkg::ADT_HIGH);
    // Pulse tracking on any change so stale peaks are dropped
    if (next_r.low_gain != r.low_gain) begin
      next_r.peak_track = 1'b1;                                // [RULE11]
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      r.st         <= adt_pkg::ADT_HIGH;
      r.cnt        <= '0;
      r.low_gain   <= 1'b0;
      r.peak_track <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // low_gain and peak_track straight from flip-flops; dwell_active decoded from the state register
  assign low_gain     = r.low_gain;
  assign peak_track   = r.peak_track;
  assign dwell_active = (r.st == adt_pkg::ADT_DWELL);

endmodule : adt_dwell_timer

//--- hdl/adt_limit.sv
// Decoder from dwell-select code to terminal count
`timescale 1ns/1ps
module adt_limit (
  // Select code
  input  wire logic [2:0]                 code,
  // Outputs
  output      logic                       agc_on,
  output      logic [adt_pkg::CNT_W-1:0]  limit
);

  // Number of cycles for a code, 2^K with K = 11 + 2*(code-1)
  function automatic logic [adt_pkg::CNT_W-1:0] dwell_cycles(input logic [2:0] c);
    logic [4:0] k;
    k = 5'(adt_pkg::K_BASE + adt_pkg::K_STEP * (int'(c) - 1));
    dwell_cycles = adt_pkg::CNT_W'(1) << k;
  endfunction : dwell_cycles

  // Code zero disables gain control
  always_comb begin
    agc_on = (code != adt_pkg::SEL_OFF);                       // [RULE1]
    limit  = agc_on ? dwell_cycles(code) : '0;                 // [RULE2]
  end

endmodule : adt_limit

//--- tb/adt_checker.sv
// Port assertions for the dwell timer
`timescale 1ns/1ps
module adt_checker (
  // Clock, reset and inputs
  input wire logic clock,
  input wire logic rst,
  input wire logic dwell_select_bit0,
  input wire logic dwell_select_bit1,
  input wire logic dwell_select_bit2,
  input wire logic level_above_upper,
  input wire logic level_below_lower,
  // Outputs
  input wire logic low_gain,
  input wire logic peak_track,
  input wire logic dwell_active
);
  logic [2:0]  c;
  logic [23:0] n;
  logic [23:0] lim;
  logic        q;
  // Last count of the dwell, and a dwell that may go on
  assign c = {dwell_select_bit2, dwell_select_bit1, dwell_select_bit0};
  assign lim = (24'h1 << (9 + 2 * c)) - 24'h1;
  assign q = dwell_active && level_below_lower && !level_above_upper && c != 3'h0;
  // Cycles spent in dwell so far
  always_ff @(posedge clock) n <= (rst || !dwell_active) ? 24'h0 : n + 24'h1;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_last;
    q && n == lim;
  endsequence
  a_off_gain: assert property (c == 3'h0 |=> !low_gain) else $error("off");
  a_upper_low: assert property (c != 3'h0 && level_above_upper
    |=> low_gain && !dwell_active) else $error("upper");
  a_track_set: assert property ($changed(low_gain) |-> peak_track) else $error("t1");
  a_track_only: assert property (peak_track |-> $changed(low_gain)) else $error("t2");
  a_dwell_low: assert property (dwell_active |-> low_gain) else $error("dl");
  a_dwell_hold: assert property (q && n < lim |=> dwell_active) else $error("dh");
  a_dwell_end: assert property (s_last |=> !low_gain && peak_track) else $error("de");
  a_low_only: assert property (dwell_active && !level_below_lower
    |=> !dwell_active) else $error("lo");
endmodule : adt_checker

//--- tb/adt_host.sv
// Host model setting the dwell code
`timescale 1ns/1ps
module adt_host (
  // Clock and wanted code
  input  wire logic       clock,
  input  wire logic [2:0] code,
  // Select pins
  output      logic       sel0 = 1'b0,
  output      logic       sel1 = 1'b0,
  output      logic       sel2 = 1'b0
);
  // Code is worked out from the interval ahead of time
  always @(posedge clock) {sel2, sel1, sel0} <= code;
endmodule : adt_host

//--- tb/tb_top.sv
// Self-checking bench for the dwell timer
`timescale 1ns/1ps
module tb_top;
  logic clock = 0, rst = 1, level_above_upper = 0, level_below_lower = 0;
  logic dwell_select_bit0, dwell_select_bit1, dwell_select_bit2;
  logic low_gain, peak_track, dwell_active;
  logic [2:0] code = 3'h0;
  logic [6:0] rows [6] = '{7'h1A, 7'h17, 7'h1E, 7'h12, 7'h08, 7'h04};
  int error_cnt = 0, checks_done = 0, n;
  initial forever #12.5 clock = ~clock;
  adt_host host (.clock, .code, .sel0(dwell_select_bit0), .sel1(dwell_select_bit1),
    .sel2(dwell_select_bit2));
  adt_dwell_timer uut (.clock, .rst, .dwell_select_bit0, .dwell_select_bit1, .dwell_select_bit2,
    .level_above_upper, .level_below_lower, .low_gain, .peak_track, .dwell_active);
  task automatic chk(input logic ok);
    checks_done++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t: output mismatch", $time);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // Full dwell plus the one low-gain cycle before the dwell starts; the host adds one cycle before the code lands
  task automatic dwell(input int k);
    @(posedge clock);
    code <= 3'((k - 9) / 2);
    level_above_upper <= 1'b1;
    repeat (3) @(posedge clock);
    level_above_upper <= 1'b0;
    n = 0;
    @(negedge clock);
    while (low_gain === 1'b1 && n < 40000) begin
      n++;
      @(negedge clock);
    end
    chk(n == (1 << k) + 1);
    chk(peak_track === 1'b1);
    if (n == 40000) summarize;
  endtask : dwell
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    // Rows: code, upper, lower, then expected gain and dwell
    foreach (rows[i]) begin
      @(posedge clock);
      {code, level_above_upper, level_below_lower} <= rows[i][6:2];
      repeat (3) @(negedge clock);
      chk({low_gain, dwell_active} === rows[i][1:0]);
    end
    // Longer codes would run past the cycle budget
    for (int k = 11; k < 16; k += 2) dwell(k);
    // Mid-run reset while in low gain; held long enough that no edge straddles it
    @(posedge clock);
    code <= 3'h1;
    level_above_upper <= 1'b1;
    repeat (2) @(negedge clock);
    chk(low_gain === 1'b1);
    @(posedge clock);
    rst <= 1'b1;
    level_above_upper <= 1'b0;
    repeat (2) @(negedge clock);
    chk({low_gain, peak_track, dwell_active} === 3'h0);
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(negedge clock);
    chk({low_gain, peak_track, dwell_active} === 3'h0);
    // First request after release acts at once
    @(posedge clock);
    level_above_upper <= 1'b1;
    repeat (2) @(negedge clock);
    chk(low_gain === 1'b1 && peak_track === 1'b1);
    summarize;
  end
endmodule : tb_top
bind adt_dwell_timer adt_checker chk_i (.clock, .rst, .dwell_select_bit0, .dwell_select_bit1,
  .dwell_select_bit2, .level_above_upper, .level_below_lower, .low_gain, .peak_track,
  .dwell_active);
